// ---- hdl/lbp_top.sv ----
`timescale 1ns/100ps
`include "lbp_defs.svh"

module lbp_top #(
  parameter int DATA_W = 16,
  parameter int PAL_W  = 32
) (
  // Clock and reset
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  // Host register port
  input  wire logic [`LBP_ADDR_W-1:0]     reg_addr,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  input  wire logic [31:0]                reg_wdata,
  output logic      [31:0]                reg_rdata,
  output logic                            reg_rvalid,
  // Pixel composite request
  input  wire logic                       pix_valid,
  input  wire logic [2:0]                 pix_depth,
  input  wire logic [23:0]                upper_rgb,
  input  wire logic [DATA_W-1:0]          upper_data,
  input  wire logic [PAL_W-1:0]           upper_pal,
  input  wire logic                       upper_indirect,
  input  wire logic                       upper_key_hit,
  input  wire logic [23:0]                lower_rgb,
  input  wire logic [7:0]                 plane_ratio,
  // Composite result
  output logic                            out_valid,
  output logic [23:0]                     out_rgb,
  output lbp_pkg::lbp_code_type           out_layer,
  output lbp_pkg::lbp_ovl_type            out_mode,
  // Current layer order
  output logic [`LBP_ORDER_W-1:0]         layer_order_select
);
  import lbp_pkg::*;

  logic [`LBP_CTL_W-1:0]   ctl_r [0:2];
  logic [`LBP_ORDER_W-1:0] order_r;
  logic [31:0]             reg_rdata_r;
  logic                    reg_rvalid_r;
  logic                    out_valid_r;
  logic [23:0]             out_rgb_r;
  lbp_code_type            out_layer_r;
  lbp_ovl_type             out_mode_r;

  lbp_code_type            code;
  logic                    has_ctl;
  logic [1:0]              ctl_idx;
  logic [`LBP_CTL_W-1:0]   ctl_sel;
  logic                    alpha_flag;
  lbp_ratio_type           ratio;
  lbp_ovl_type             mode;
  logic [23:0]             mixed;
  logic [31:0]             rd_nxt;

  // Effective ratio: register or plane value, optional 1/256 step
  function automatic lbp_ratio_type eff_ratio(
    input logic [`LBP_CTL_W-1:0] ctl,
    input logic [7:0]            plane
  );
    logic [7:0] base;
    base = ctl[`LBP_PLANE_BIT] ? plane : ctl[`LBP_RATIO_MSB:0];
    if (ctl[`LBP_INC_BIT] && (base != 8'h00))
    begin
      eff_ratio = {1'b0, base} + 9'h001;
    end
    else
    begin
      eff_ratio = {1'b0, base};
    end
  endfunction

  // Layer code held in one slot of the order register
  function automatic lbp_code_type slot_code(
    input logic [`LBP_ORDER_W-1:0] order,
    input logic [2:0]              depth
  );
    if (depth < 3'(`LBP_ORDER_SLOTS))
    begin
      slot_code = order[4*depth +: 4];
    end
    else
    begin
      slot_code = `LBP_CODE_NONE;
    end
  endfunction

  // Control registers, one set for each of layers 1 to 3
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctl_r[0] <= `LBP_CTL_RST;
      ctl_r[1] <= `LBP_CTL_RST;
      ctl_r[2] <= `LBP_CTL_RST;
    end
    else if (reg_wr)
    begin
      if (reg_addr == `LBP_OFS_L1)
      begin
        ctl_r[0] <= reg_wdata[`LBP_CTL_W-1:0] & `LBP_CTL_MASK;
      end
      else if (reg_addr == `LBP_OFS_L2)
      begin
        ctl_r[1] <= reg_wdata[`LBP_CTL_W-1:0] & `LBP_CTL_MASK;
      end
      else if (reg_addr == `LBP_OFS_L3)
      begin
        ctl_r[2] <= reg_wdata[`LBP_CTL_W-1:0] & `LBP_CTL_MASK;
      end
    end
  end

  // Layer order register
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      order_r <= `LBP_ORDER_RST;
    end
    else if (reg_wr && (reg_addr == `LBP_OFS_ORDER))
    begin
      order_r <= reg_wdata[`LBP_ORDER_W-1:0] & `LBP_ORDER_MASK;
    end
  end

  // Read decode; unmapped offsets read zero
  always_comb
  begin
    if (reg_addr == `LBP_OFS_ORDER)
    begin
      rd_nxt = {8'h00, order_r};
    end
    else if (reg_addr == `LBP_OFS_L1)
    begin
      rd_nxt = {15'h0000, ctl_r[0]};
    end
    else if (reg_addr == `LBP_OFS_L2)
    begin
      rd_nxt = {15'h0000, ctl_r[1]};
    end
    else if (reg_addr == `LBP_OFS_L3)
    begin
      rd_nxt = {15'h0000, ctl_r[2]};
    end
    else
    begin
      rd_nxt = 32'h00000000;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      reg_rdata_r  <= 32'h00000000;
      reg_rvalid_r <= 1'b0;
    end
    else
    begin
      reg_rvalid_r <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata_r <= rd_nxt;
      end
    end
  end

  // Upper layer, its controls and overlay mode
  always_comb
  begin
    code    = slot_code(order_r, pix_depth);
    has_ctl = (code >= 4'h1) && (code <= 4'h3);
    ctl_idx = 2'(code - 4'h1);
    ctl_sel = has_ctl ? ctl_r[ctl_idx] : `LBP_CTL_RST;
    // Alpha enable bit of the pixel
    alpha_flag = upper_indirect ? upper_pal[PAL_W-1] : upper_data[DATA_W-1];
    ratio = eff_ratio(ctl_sel, plane_ratio);
    if (code > `LBP_CODE_MAXLAYER)
    begin
      mode = LBP_OVL_LOWER;
    end
    else if (has_ctl && ctl_sel[`LBP_ON_BIT])
    begin
      // Blending only where software also marked the pixel with alpha
      mode = alpha_flag ? LBP_OVL_BLEND : LBP_OVL_UPPER;
    end
    else
    begin
      mode = upper_key_hit ? LBP_OVL_LOWER : LBP_OVL_UPPER;
    end
  end

  // Per-component mixers
  for (genvar c = 0; c < 3; c++)
  begin : g_comp
    lbp_mix #(
      .COMP_W (8)
    ) u_mix (
      .upper (upper_rgb[8*c +: 8]),
      .lower (lower_rgb[8*c +: 8]),
      .ratio (ratio),
      .swap  (ctl_sel[`LBP_SEL_BIT]),
      .mixed (mixed[8*c +: 8])
    );
  end

  // Composite result, one cycle after the request
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      out_valid_r <= 1'b0;
      out_rgb_r   <= 24'h000000;
      out_layer_r <= `LBP_CODE_NONE;
      out_mode_r  <= LBP_OVL_LOWER;
    end
    else
    begin
      out_valid_r <= pix_valid;
      if (pix_valid)
      begin
        out_layer_r <= code;
        out_mode_r  <= mode;
        case (mode)
          LBP_OVL_BLEND: out_rgb_r <= mixed;
          LBP_OVL_UPPER: out_rgb_r <= upper_rgb;
          default:       out_rgb_r <= lower_rgb;
        endcase
      end
    end
  end

  assign reg_rdata          = reg_rdata_r;
  assign reg_rvalid         = reg_rvalid_r;
  assign out_valid          = out_valid_r;
  assign out_rgb            = out_rgb_r;
  assign out_layer          = out_layer_r;
  assign out_mode           = out_mode_r;
  assign layer_order_select = order_r;

endmodule

// ---- hdl/lbp_defs.svh ----
`ifndef LBP_DEFS_SVH
`define LBP_DEFS_SVH

`define LBP_ADDR_W        12
`define LBP_OFS_ORDER     12'h180
`define LBP_OFS_L1        12'h188
`define LBP_OFS_L2        12'h18C
`define LBP_OFS_L3        12'h190

`define LBP_CTL_W         17
`define LBP_RATIO_MSB     7
`define LBP_PLANE_BIT     13
`define LBP_INC_BIT       14
`define LBP_SEL_BIT       15
`define LBP_ON_BIT        16
`define LBP_CTL_MASK      17'h1E0FF
`define LBP_CTL_RST       17'h00000

`define LBP_ORDER_W       24
`define LBP_ORDER_MASK    24'h777777
`define LBP_ORDER_RST     24'h543210
`define LBP_ORDER_SLOTS   6
`define LBP_CODE_NONE     4'h7
`define LBP_CODE_MAXLAYER 4'h5

`define LBP_RATIO_ONE     9'h100
`define LBP_RATIO_SHIFT   8
`define LBP_COMP_MAX      8'hFF

`endif

// ---- hdl/lbp_pkg.sv ----
package lbp_pkg;

  typedef logic [3:0] lbp_code_type;

  typedef logic [8:0] lbp_ratio_type;

  typedef enum logic [1:0] {
    LBP_OVL_LOWER,
    LBP_OVL_UPPER,
    LBP_OVL_BLEND
  } lbp_ovl_type;

endpackage

// ---- hdl/lbp_mix.sv ----
`timescale 1ns/100ps
`include "lbp_defs.svh"

module lbp_mix #(
  parameter int COMP_W = 8
) (
  // Pixel components
  input  wire logic [COMP_W-1:0]   upper,
  input  wire logic [COMP_W-1:0]   lower,
  // Weighting
  input  wire lbp_pkg::lbp_ratio_type ratio,
  input  wire logic                swap,
  // Result
  output logic      [COMP_W-1:0]   mixed
);
  import lbp_pkg::*;

  logic [8:0]          w_up;
  logic [8:0]          w_lo;
  logic [COMP_W+9:0]   sum;
  logic [COMP_W+9:0]   scaled;

  always_comb
  begin
    w_up = swap ? (`LBP_RATIO_ONE - ratio) : ratio;
    w_lo = swap ? ratio : (`LBP_RATIO_ONE - ratio);
    sum = (COMP_W+10)'(upper) * (COMP_W+10)'(w_up)
        + (COMP_W+10)'(lower) * (COMP_W+10)'(w_lo);
    scaled = sum >> `LBP_RATIO_SHIFT;
    // Clip to the component range
    if (scaled > (COMP_W+10)'({COMP_W{1'b1}}))
    begin
      mixed = {COMP_W{1'b1}};
    end
    else
    begin
      mixed = scaled[COMP_W-1:0];
    end
  end

endmodule

// ---- testbench/lbp_top_sva.sv ----
`timescale 1ns/100ps
module lbp_top_sva (
  // Clock and reset
  input wire logic                  sys_clk,
  input wire logic                  rst,
  // Register port
  input wire logic [11:0]           reg_addr,
  input wire logic                  reg_rd,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  reg_rvalid,
  // Pixel port
  input wire logic                  pix_valid,
  input wire logic [2:0]            pix_depth,
  input wire logic [23:0]           out_rgb,
  input wire logic                  out_valid,
  input wire lbp_pkg::lbp_code_type out_layer,
  input wire lbp_pkg::lbp_ovl_type  out_mode,
  input wire logic [23:0]           layer_order_select
);
  import lbp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic blk_rd;
  logic map_rd;
  assign blk_rd = reg_rd && (reg_addr inside {12'h188, 12'h18C, 12'h190});
  assign map_rd = blk_rd || (reg_rd && reg_addr == 12'h180);
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read answer without read");
  blk_resv_a: assert property (blk_rd |=> (reg_rdata & 32'hFFFE1F00) == 32'h0)
    else $error("reserved blend bits not zero");
  unmap_zero_a: assert property (reg_rd && !map_rd |=> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  pix_answer_a: assert property (pix_valid |=> out_valid)
    else $error("pixel not answered");
  outv_cause_a: assert property (out_valid |-> $past(pix_valid))
    else $error("pixel answer without request");
  order_resv_a: assert property ((layer_order_select & 24'h888888) == 24'h0)
    else $error("order reserved bits set");
  no_layer_a: assert property (pix_valid && pix_depth > 3'h5 |=>
    out_layer == 4'h7 && out_mode == LBP_OVL_LOWER) else $error("no layer not lower");
  blend_layer_a: assert property (out_mode == LBP_OVL_BLEND |->
    out_layer inside {4'h1, 4'h2, 4'h3}) else $error("blend on unparameterised layer");
  out_hold_a: assert property (!pix_valid && !rst |=> $stable(out_rgb) && $stable(out_mode))
    else $error("result changed without request");
  cover property (out_valid && out_mode == LBP_OVL_BLEND);
  cover property (out_valid && out_layer == 4'h7);
  cover property (blk_rd ##1 reg_rvalid);
endmodule
bind lbp_top lbp_top_sva i_lbp_top_sva (.sys_clk, .rst, .reg_addr, .reg_rd, .reg_rdata,
  .reg_rvalid, .pix_valid, .pix_depth, .out_rgb, .out_valid, .out_layer, .out_mode,
  .layer_order_select);

// ---- testbench/lbp_top_tb.sv ----
`timescale 1ns/100ps
module lbp_top_tb;
  import lbp_pkg::*;
  localparam logic [23:0] U = 24'hF08040;
  localparam logic [23:0] L = 24'h10C0FF;
  logic sys_clk, rst, reg_wr, reg_rd, reg_rvalid, pix_valid, upper_indirect;
  logic upper_key_hit, out_valid;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, upper_pal;
  logic [2:0] pix_depth;
  logic [23:0] upper_rgb, lower_rgb, out_rgb, layer_order_select;
  logic [15:0] upper_data;
  logic [7:0] plane_ratio;
  lbp_code_type out_layer;
  lbp_ovl_type out_mode;
  int failures, check_count;
  lbp_top i_lbp_top (.sys_clk, .rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .reg_rvalid, .pix_valid, .pix_depth, .upper_rgb, .upper_data, .upper_pal,
    .upper_indirect, .upper_key_hit, .lower_rgb, .plane_ratio, .out_valid, .out_rgb,
    .out_layer, .out_mode, .layer_order_select);
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  function automatic logic [23:0] mix(input logic [16:0] c, input logic [7:0] pl);
    logic [8:0] b;
    logic [8:0] w;
    logic [23:0] r;
    b = c[13] ? {1'b0, pl} : {1'b0, c[7:0]};
    b = b + 9'((c[14] && b != 9'h0) ? 1 : 0);
    w = c[15] ? 9'h100 - b : b;
    for (int i = 0; i < 24; i += 8)
      r[i+:8] = 8'((U[i+:8] * 17'(w) + L[i+:8] * 17'(9'h100 - w)) >> 8);
    return r;
  endfunction
  task cmp(input logic [32:0] g, e);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  task end_sim;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task rg(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr    <= w;
    reg_rd    <= !w;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 if (!w) cmp({reg_rvalid, reg_rdata}, {1'b1, d});
  endtask
  // Write the control word to offset 184h + 4*d, then composite one pixel at depth d
  task px(input logic [2:0] d, input logic [16:0] c, input logic [7:0] pl,
          input logic a, ind, k, input lbp_ovl_type m, input lbp_code_type y);
    rg(1'b1, 12'(12'h184 + 4 * d), {15'h0, c});
    @(posedge sys_clk);
    pix_valid      <= 1'b1;
    pix_depth      <= d;
    plane_ratio    <= pl;
    upper_indirect <= ind;
    upper_key_hit  <= k;
    upper_data     <= {a ^ ind, 15'h0};
    upper_pal      <= {a ^ ~ind, 31'h0};
    @(posedge sys_clk);
    pix_valid <= 1'b0;
    #1 cmp({out_valid, out_mode, out_layer, out_rgb},
      {1'b1, m, y, m == LBP_OVL_BLEND ? mix(c, pl) : (m == LBP_OVL_UPPER ? U : L)});
  endtask
  initial
  begin
    {reg_wr, reg_rd, pix_valid, upper_indirect, upper_key_hit} = '0;
    {reg_addr, reg_wdata, upper_pal, pix_depth, upper_data, plane_ratio} = '0;
    upper_rgb = U;
    lower_rgb = L;
    rst = 1'b1;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) rg(1'b0, 12'(12'h188 + 4 * i), 32'h0);
    rg(1'b0, 12'h180, 32'h00543210);
    rg(1'b1, 12'h18C, 32'hFFFFFFFF);
    rg(1'b0, 12'h18C, 32'h0001E0FF);
    rg(1'b0, 12'h188, 32'h0);
    rg(1'b0, 12'h184, 32'h0);
    px(3'h1, 17'h10040, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_BLEND, 4'h1);
    px(3'h2, 17'h14040, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_BLEND, 4'h2);
    px(3'h3, 17'h14000, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_BLEND, 4'h3);
    px(3'h1, 17'h18040, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_BLEND, 4'h1);
    px(3'h2, 17'h16011, 8'hFF, 1'b1, 1'b0, 1'b0, LBP_OVL_BLEND, 4'h2);
    px(3'h3, 17'h120C0, 8'h33, 1'b1, 1'b1, 1'b0, LBP_OVL_BLEND, 4'h3);
    px(3'h3, 17'h100C0, 8'h00, 1'b0, 1'b1, 1'b0, LBP_OVL_UPPER, 4'h3);
    px(3'h1, 17'h000FF, 8'h00, 1'b1, 1'b0, 1'b1, LBP_OVL_LOWER, 4'h1);
    px(3'h2, 17'h0E0FF, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_UPPER, 4'h2);
    px(3'h0, 17'h10080, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_UPPER, 4'h0);
    px(3'h6, 17'h10080, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_LOWER, 4'h7);
    rg(1'b1, 12'h180, 32'hFFFFFFF3);
    rg(1'b0, 12'h180, 32'h00777773);
    cmp({9'h0, layer_order_select}, 33'h000777773);
    px(3'h0, 17'h10080, 8'h00, 1'b0, 1'b0, 1'b0, LBP_OVL_UPPER, 4'h3);
    px(3'h1, 17'h10080, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_LOWER, 4'h7);
    rg(1'b1, 12'h180, 32'h00000046);
    px(3'h0, 17'h10080, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_LOWER, 4'h6);
    px(3'h1, 17'h10080, 8'h00, 1'b1, 1'b0, 1'b0, LBP_OVL_UPPER, 4'h4);
    // One-edge reset in mid-run brings back every reset value
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    #1 cmp({out_valid, out_mode, out_layer, out_rgb},
      {1'b0, LBP_OVL_LOWER, 4'h7, 24'h0});
    cmp({reg_rvalid, reg_rdata}, 33'h0);
    rg(1'b0, 12'h180, 32'h00543210);
    rg(1'b0, 12'h190, 32'h0);
    end_sim;
  end
  // Stops a hung run; the sequence needs well under a microsecond
  initial
  begin
    #5000;
    failures++;
    end_sim;
  end
endmodule
